// [pkg/ihc_pkg.sv]
// ihc_pkg: register map, field positions, reset values and state type
package ihc_pkg;

    // register byte offsets
    localparam logic [7:0] IHC_OFS_INT_STS = 8'h0c;
    localparam logic [7:0] IHC_OFS_HARDWARE_CONFIGURATION = 8'h10;
    localparam logic [7:0] IHC_OFS_EVT_STS = 8'h14;
    localparam logic [7:0] IHC_OFS_EVT_MASK = 8'h18;
    localparam logic [7:0] IHC_OFS_WAKE_SEL = 8'h1c;

    // interrupt status field positions
    localparam int IHC_INT_MAC_ERR_BIT = 15;
    localparam int IHC_INT_FRAME_PEND_BIT = 12;
    localparam int IHC_INT_PIN_LSB = 0;

    // hardware configuration field positions
    localparam int IHC_HW_LED_LSB = 20;
    localparam int IHC_HW_DET_STS_BIT = 15;
    localparam int IHC_HW_DET_TRIG_BIT = 14;
    localparam int IHC_HW_DESC_SEL_BIT = 13;
    localparam int IHC_HW_PROTECT_BIT = 12;

    // event status / mask field positions
    localparam int IHC_EVT_REATTACH_BIT = 0;
    localparam int IHC_EVT_MAC_ERR_BIT = 1;
    localparam int IHC_EVT_PIN_BIT = 2;
    localparam int IHC_EVT_FRAME_BIT = 3;
    localparam int IHC_EVT_W = 4;

    // reset values
    localparam logic [3:0] IHC_LED_EN_RST = 4'h0;
    localparam logic IHC_DESC_SEL_RST = 1'b0;
    localparam logic IHC_PROTECT_RST = 1'b0;
    localparam logic IHC_DET_STS_RST = 1'b0;
    localparam logic [3:0] IHC_EVT_MASK_RST = 4'h0;
    localparam logic [11:0] IHC_WAKE_SEL_RST = 12'h000;
    localparam logic [31:0] IHC_RDATA_RST = 32'h0000_0000;

    // usb attach state
    typedef enum logic {
        IHC_ATTACHED,
        IHC_DETACHED
    } ihc_det_state_t;

endpackage : ihc_pkg

// [rtl/ihc_detach_fsm.sv]
// ihc_detach_fsm: usb detach and reattach sequencer
`timescale 1ns/1ps
module ihc_detach_fsm
    import ihc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic link_up,
    input wire logic wake_hit,
    output logic detached,
    output logic reattach
);
    typedef struct packed {
        ihc_det_state_t state;
        logic reattach;
    } ihc_fsm_state_t;

    ihc_fsm_state_t s_q;
    ihc_fsm_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.reattach = 1'b0;
        case (s_q.state)
            IHC_ATTACHED: begin
                if (start) begin
                    s_d.state = IHC_DETACHED;
                end
            end
            IHC_DETACHED: begin
                // off the bus until link or a selected pin wakes us
                if (link_up || wake_hit) begin
                    s_d.state = IHC_ATTACHED;
                    s_d.reattach = 1'b1;
                end
            end
            default: begin
                s_d.state = IHC_ATTACHED;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q.state <= IHC_ATTACHED;
            s_q.reattach <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign detached = (s_q.state == IHC_DETACHED);
    assign reattach = s_q.reattach;

endmodule : ihc_detach_fsm

// [rtl/ihc_regs.sv]
// ihc_regs: interrupt status and hardware configuration register bank
//
// What this block does
// - bit 15 flags any mac error condition
// - bit 15 is a level of error bits
// - bit 12 shows usb tx frame pending
// - bits 11:0 are level-set pin flags
// - clearing a pin flag clears its wake
// - bits 23:20 enable indicator pins, protected
// - bit 15 detach status, write one clears
// - writing one to bit 14 detaches usb
// - bit 13 selects descriptor source, protected
// - select used only without eeprom or otp
// - protect bit keeps fields across non-por resets
`timescale 1ns/1ps
module ihc_regs
    import ihc_pkg::*;
#(
    parameter int N_PINS = 12,
    parameter int ERR_BITS = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic por_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [ERR_BITS-1:0] mac_error_register,
    input wire logic usb_tx_frame_pending,
    input wire logic [N_PINS-1:0] gpio_pin,
    input wire logic phy_link_pin,
    input wire logic eeprom_present,
    input wire logic otp_configured,
    output logic [3:0] indicator_pin_enable,
    output logic usb_detach,
    output logic desc_from_ram,
    output logic [N_PINS-1:0] pin_wake_clear,
    output logic irq
);
    if (N_PINS < 1 || N_PINS > 12) begin : g_chk_pins
        $error("ihc_regs: N_PINS must be 1 to 12");
    end
    if (ERR_BITS < 1 || ERR_BITS > 32) begin : g_chk_err
        $error("ihc_regs: ERR_BITS must be 1 to 32");
    end

    typedef struct packed {
        logic [N_PINS-1:0] pin_interrupt_flag;
        logic [N_PINS-1:0] wake_clr;
        logic [3:0] indicator_en;
        logic cable_detach_status;
        logic descriptor_source_select;
        logic protect;
        logic [IHC_EVT_W-1:0] evt;
        logic [IHC_EVT_W-1:0] evt_mask;
        logic [11:0] wake_sel;
        logic mac_err_prev;
        logic frame_prev;
        logic [31:0] rd_data;
    } ihc_regs_state_t;

    ihc_regs_state_t s_q;
    ihc_regs_state_t s_d;

    logic rst_all_n;
    logic [N_PINS-1:0] pin_level;
    logic link_level;
    logic detached;
    logic reattach;
    logic mac_err_any;
    logic int_wr;
    logic hw_wr;
    logic evt_rd;
    logic det_start;
    logic wake_hit;
    logic [N_PINS-1:0] pin_clr;
    logic [N_PINS-1:0] pin_next;
    logic [IHC_EVT_W-1:0] evt_set;
    logic [31:0] rd_mux;
    logic [11:0] wake_sel_pins;

    assign rst_all_n = resetn & por_n;

    ihc_sync3 #(
        .W(N_PINS)
    ) u_pin_sync (
        .core_clk(core_clk),
        .resetn(rst_all_n),
        .async_in(gpio_pin),
        .level(pin_level)
    );

    ihc_sync3 #(
        .W(1)
    ) u_link_sync (
        .core_clk(core_clk),
        .resetn(rst_all_n),
        .async_in(phy_link_pin),
        .level(link_level)
    );

    // detach request comes straight from the write decode
    assign det_start = hw_wr && reg_wdata[IHC_HW_DET_TRIG_BIT];
    assign wake_sel_pins = s_q.wake_sel;
    assign wake_hit = |(pin_level & wake_sel_pins[N_PINS-1:0]);

    ihc_detach_fsm u_detach (
        .core_clk(core_clk),
        .resetn(rst_all_n),
        .start(det_start),
        .link_up(link_level),
        .wake_hit(wake_hit),
        .detached(detached),
        .reattach(reattach)
    );

    always_comb begin
        s_d = s_q;
        mac_err_any = |mac_error_register;
        int_wr = reg_wr && (reg_addr == IHC_OFS_INT_STS);
        hw_wr = reg_wr && (reg_addr == IHC_OFS_HARDWARE_CONFIGURATION);
        evt_rd = reg_rd && (reg_addr == IHC_OFS_EVT_STS);

        // pin flags: level source wins over a write-one clear
        pin_clr = int_wr ? reg_wdata[IHC_INT_PIN_LSB +: N_PINS] : '0;
        pin_next = (s_q.pin_interrupt_flag & ~pin_clr) | pin_level;
        s_d.pin_interrupt_flag = pin_next;
        s_d.wake_clr = pin_clr;

        if (hw_wr) begin
            s_d.indicator_en = reg_wdata[IHC_HW_LED_LSB +: 4];
            s_d.descriptor_source_select = reg_wdata[IHC_HW_DESC_SEL_BIT];
            s_d.protect = reg_wdata[IHC_HW_PROTECT_BIT];
        end
        // detach status: reattach set wins over the clear
        s_d.cable_detach_status = (s_q.cable_detach_status
            & ~(hw_wr && reg_wdata[IHC_HW_DET_STS_BIT])) | reattach;

        if (reg_wr && (reg_addr == IHC_OFS_EVT_MASK)) begin
            s_d.evt_mask = reg_wdata[IHC_EVT_W-1:0];
        end
        if (reg_wr && (reg_addr == IHC_OFS_WAKE_SEL)) begin
            s_d.wake_sel = reg_wdata[11:0];
        end

        // sticky events, cleared by reading, set wins
        evt_set = '0;
        evt_set[IHC_EVT_REATTACH_BIT] = reattach;
        evt_set[IHC_EVT_MAC_ERR_BIT] = mac_err_any && !s_q.mac_err_prev;
        evt_set[IHC_EVT_PIN_BIT] = |(pin_next & ~s_q.pin_interrupt_flag);
        evt_set[IHC_EVT_FRAME_BIT] = usb_tx_frame_pending && !s_q.frame_prev;
        s_d.evt = (evt_rd ? '0 : s_q.evt) | evt_set;
        s_d.mac_err_prev = mac_err_any;
        s_d.frame_prev = usb_tx_frame_pending;

        // read data, reserved bits zero
        rd_mux = IHC_RDATA_RST;
        case (reg_addr)
            IHC_OFS_INT_STS: begin
                rd_mux[IHC_INT_MAC_ERR_BIT] = mac_err_any;
                rd_mux[IHC_INT_FRAME_PEND_BIT] = usb_tx_frame_pending;
                rd_mux[IHC_INT_PIN_LSB +: N_PINS] = s_q.pin_interrupt_flag;
            end
            IHC_OFS_HARDWARE_CONFIGURATION: begin
                rd_mux[IHC_HW_LED_LSB +: 4] = s_q.indicator_en;
                rd_mux[IHC_HW_DET_STS_BIT] = s_q.cable_detach_status;
                rd_mux[IHC_HW_DESC_SEL_BIT] = s_q.descriptor_source_select;
                rd_mux[IHC_HW_PROTECT_BIT] = s_q.protect;
            end
            IHC_OFS_EVT_STS: begin
                rd_mux[IHC_EVT_W-1:0] = s_q.evt;
            end
            IHC_OFS_EVT_MASK: begin
                rd_mux[IHC_EVT_W-1:0] = s_q.evt_mask;
            end
            IHC_OFS_WAKE_SEL: begin
                rd_mux[11:0] = s_q.wake_sel;
            end
            default: begin
                rd_mux = IHC_RDATA_RST;
            end
        endcase
        s_d.rd_data = reg_rd ? rd_mux : IHC_RDATA_RST;
    end

    always_ff @(posedge core_clk) begin
        if (!por_n) begin
            s_q <= '0;
            s_q.indicator_en <= IHC_LED_EN_RST;
            s_q.descriptor_source_select <= IHC_DESC_SEL_RST;
            s_q.protect <= IHC_PROTECT_RST;
            s_q.cable_detach_status <= IHC_DET_STS_RST;
            s_q.evt_mask <= IHC_EVT_MASK_RST;
            s_q.wake_sel <= IHC_WAKE_SEL_RST;
            s_q.rd_data <= IHC_RDATA_RST;
        end else if (!resetn) begin
            s_q <= '0;
            s_q.cable_detach_status <= IHC_DET_STS_RST;
            s_q.evt_mask <= IHC_EVT_MASK_RST;
            s_q.wake_sel <= IHC_WAKE_SEL_RST;
            s_q.rd_data <= IHC_RDATA_RST;
            // protected fields survive any reset but power-on
            if (s_q.protect) begin
                s_q.indicator_en <= s_q.indicator_en;
                s_q.descriptor_source_select <= s_q.descriptor_source_select;
                s_q.protect <= s_q.protect;
            end else begin
                s_q.indicator_en <= IHC_LED_EN_RST;
                s_q.descriptor_source_select <= IHC_DESC_SEL_RST;
                s_q.protect <= IHC_PROTECT_RST;
            end
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rd_data;
    assign indicator_pin_enable = s_q.indicator_en;
    assign usb_detach = detached;
    assign desc_from_ram = s_q.descriptor_source_select
        && !eeprom_present && !otp_configured;
    assign pin_wake_clear = s_q.wake_clr;
    assign irq = |(s_q.evt & s_q.evt_mask);

    default clocking ck @(posedge core_clk);
    endclocking
    default disable iff (!resetn || !por_n);

    property p_mac_err;
        reg_rd && (reg_addr == IHC_OFS_INT_STS)
            |=> reg_rdata[IHC_INT_MAC_ERR_BIT] == $past(mac_err_any);
    endproperty
    a_mac_err: assert property (p_mac_err) else $error("mac error bit wrong");

    property p_mac_err_level;
        (|mac_error_register) ##0 reg_rd && (reg_addr == IHC_OFS_INT_STS)
            |=> reg_rdata[IHC_INT_MAC_ERR_BIT];
    endproperty
    a_mac_err_level: assert property (p_mac_err_level) else $error("mac error dropped");

    property p_frame_pend;
        reg_rd && (reg_addr == IHC_OFS_INT_STS)
            |=> reg_rdata[IHC_INT_FRAME_PEND_BIT] == $past(usb_tx_frame_pending);
    endproperty
    a_frame_pend: assert property (p_frame_pend) else $error("frame pending bit wrong");

    property p_pin_flag;
        (pin_level != '0) |=> ((s_q.pin_interrupt_flag & $past(pin_level)) == $past(pin_level));
    endproperty
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag not held by level");

    property p_wake_clr;
        int_wr |=> pin_wake_clear == $past(reg_wdata[N_PINS-1:0]) ##1 pin_wake_clear == '0
            || $past(int_wr);
    endproperty
    a_wake_clr: assert property (p_wake_clr) else $error("wake clear pulse wrong");

    property p_led_write;
        hw_wr |=> indicator_pin_enable == $past(reg_wdata[IHC_HW_LED_LSB +: 4]);
    endproperty
    a_led_write: assert property (p_led_write) else $error("indicator enable not written");

    property p_det_sts_clr;
        hw_wr && reg_wdata[IHC_HW_DET_STS_BIT] && !reattach |=> !s_q.cable_detach_status;
    endproperty
    a_det_sts_clr: assert property (p_det_sts_clr) else $error("detach status not cleared");

    property p_detach;
        det_start && !usb_detach |=> usb_detach;
    endproperty
    a_detach: assert property (p_detach) else $error("detach not started");

    property p_reattach;
        usb_detach && (link_level || wake_hit) |=> !usb_detach ##1 s_q.cable_detach_status;
    endproperty
    a_reattach: assert property (p_reattach) else $error("reattach missing");

    property p_desc_sel;
        hw_wr ##1 (!eeprom_present && !otp_configured)
            |-> desc_from_ram == $past(reg_wdata[IHC_HW_DESC_SEL_BIT]);
    endproperty
    a_desc_sel: assert property (p_desc_sel) else $error("descriptor select wrong");

    property p_desc_ignored;
        eeprom_present || otp_configured |-> !desc_from_ram;
    endproperty
    a_desc_ignored: assert property (p_desc_ignored) else $error("select not ignored");

    property p_protect;
        @(posedge core_clk) disable iff (!por_n)
        !resetn && s_q.protect |=> indicator_pin_enable == $past(indicator_pin_enable);
    endproperty
    a_protect: assert property (p_protect) else $error("protected field lost");

    property p_reserved;
        reg_rd && (reg_addr == IHC_OFS_HARDWARE_CONFIGURATION) |=> reg_rdata[31:24] == 8'h00
            && reg_rdata[19:16] == 4'h0 && reg_rdata[11:0] == 12'h000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_trig_zero;
        reg_rd && (reg_addr == IHC_OFS_HARDWARE_CONFIGURATION) |=> !reg_rdata[IHC_HW_DET_TRIG_BIT];
    endproperty
    a_trig_zero: assert property (p_trig_zero) else $error("detach trigger reads one");

endmodule : ihc_regs

// [rtl/ihc_sync3.sv]
// ihc_sync3: three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ihc_sync3 #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } ihc_sync_state_t;

    ihc_sync_state_t s_q;
    ihc_sync_state_t s_d;
    logic [W-1:0] agree;

    if (W < 1) begin : g_chk
        $error("ihc_sync3: width must be at least one");
    end

    always_comb begin
        s_d = s_q;
        s_d.s1 = async_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // level moves only when stages two and three agree
        agree = ~(s_q.s2 ^ s_q.s3);
        s_d.lvl = (s_q.lvl & ~agree) | (s_q.s3 & agree);
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;

endmodule : ihc_sync3

// [tb/ihc_regs_tb_top.sv]
// ihc_regs_tb_top: self-checking bench for the register bank
`timescale 1ns/1ps
module ihc_regs_tb_top
    import ihc_pkg::*;
;
    logic core_clk;
    logic resetn;
    logic por_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [7:0] mac_err;
    logic frame_pend;
    logic [11:0] gpio_pin;
    logic phy_link;
    logic eeprom_present;
    logic otp_configured;
    logic [3:0] indicator_pin_enable;
    logic usb_detach;
    logic desc_from_ram;
    logic [11:0] pin_wake_clear;
    logic irq;
    logic rd_seen;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int bad_count;
    int checks_done;
    int cycles;
    int seed;
    logic [31:0] r;
    logic [31:0] m;

    ihc_regs DUT (
        .core_clk(core_clk), .resetn(resetn), .por_n(por_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mac_error_register(mac_err), .usb_tx_frame_pending(frame_pend),
        .gpio_pin(gpio_pin), .phy_link_pin(phy_link), .eeprom_present(eeprom_present),
        .otp_configured(otp_configured), .indicator_pin_enable(indicator_pin_enable),
        .usb_detach(usb_detach), .desc_from_ram(desc_from_ram),
        .pin_wake_clear(pin_wake_clear), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    // compare of a read result, bits outside the mask are ignored
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        checks_done++;
        if ((got & msk) !== (exp & msk)) begin
            bad_count++;
            $display("mismatch at %0t read got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd

    // compare of a port value sampled at the falling edge
    task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t port got %h exp %h", $time, got, exp);
        end
    endtask : cmp_port

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        msk_q.push_back(msk);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic end_test(input string name);
        cyc(2);
        $display("test %s done", name);
    endtask : end_test

    // read data stands in the cycle after the strobe only
    always @(posedge core_clk) begin
        rd_seen <= reg_rd;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            conclude();
        end
    end

    always @(negedge core_clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            cmp_rd(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    initial begin
        seed = 65873;
        {resetn, por_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {mac_err, frame_pend, gpio_pin, phy_link, eeprom_present, otp_configured} = '0;
        {rd_seen, bad_count, checks_done, cycles} = '0;
        cyc(10);
        resetn <= 1'b1;
        por_n <= 1'b1;
        cyc(6);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h0c, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF);
        rd(8'h1c, 32'h0000_0000, 32'hFFFF_FFFF);
        end_test("reset");
        wr(8'h10, 32'hFFFF_BFFF);
        rd(8'h10, 32'h00F0_3000, 32'hFFFF_FFFF);
        @(negedge core_clk);
        cmp_port({28'h000_0000, indicator_pin_enable}, 32'h0000_000F);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            eeprom_present <= i[0];
            otp_configured <= i[1];
            @(negedge core_clk);
            cmp_port({31'h0, desc_from_ram}, {31'h0, i == 0});
        end
        end_test("config");
        resetn <= 1'b0;
        cyc(2);
        resetn <= 1'b1;
        rd(8'h10, 32'h00F0_3000, 32'hFFFF_FFFF);
        @(negedge core_clk);
        cmp_port({28'h000_0000, indicator_pin_enable}, 32'h0000_000F);
        @(posedge core_clk);
        por_n <= 1'b0;
        cyc(2);
        por_n <= 1'b1;
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        end_test("protect");
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            r = $random(seed);
            mac_err <= (i == 0) ? 8'h00 : r[7:0];
            frame_pend <= r[8];
            @(posedge core_clk);
            m = {16'h0, |mac_err, 2'b00, frame_pend, 12'h000};
            rd(8'h0c, m, 32'hFFFF_FFFF);
        end
        @(posedge core_clk);
        mac_err <= 8'h00;
        frame_pend <= 1'b0;
        end_test("status");
        r = $random(seed);
        gpio_pin <= r[11:0];
        cyc(8);
        rd(8'h0c, {20'h0_0000, r[11:0]}, 32'hFFFF_FFFF);
        gpio_pin <= 12'h800;
        cyc(8);
        rd(8'h0c, {20'h0_0000, r[11:0] | 12'h800}, 32'hFFFF_FFFF);
        wr(8'h0c, 32'h0000_FFFF);
        @(negedge core_clk);
        cmp_port({20'h0_0000, pin_wake_clear}, 32'h0000_0FFF);
        rd(8'h0c, 32'h0000_0800, 32'hFFFF_FFFF);
        end_test("pins");
        wr(8'h1c, 32'h0000_0000);
        wr(8'h10, 32'h0000_4000);
        @(negedge core_clk);
        cmp_port({31'h0, usb_detach}, 32'h0000_0001);
        wr(8'h10, 32'h0000_0000);
        cyc(6);
        @(negedge core_clk);
        cmp_port({31'h0, usb_detach}, 32'h0000_0001);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        phy_link <= 1'b1;
        for (int i = 0; i < 20 && usb_detach !== 1'b0; i++) @(negedge core_clk);
        cmp_port({31'h0, usb_detach}, 32'h0000_0000);
        rd(8'h10, 32'h0000_8000, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0000_8000);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF);
        phy_link <= 1'b0;
        cyc(8);
        end_test("link detach");
        wr(8'h1c, 32'h0000_0004);
        wr(8'h10, 32'h0000_4000);
        cyc(8);
        @(negedge core_clk);
        cmp_port({31'h0, usb_detach}, 32'h0000_0001);
        @(posedge core_clk);
        gpio_pin <= 12'h004;
        for (int i = 0; i < 20 && usb_detach !== 1'b0; i++) @(negedge core_clk);
        cmp_port({31'h0, usb_detach}, 32'h0000_0000);
        rd(8'h10, 32'h0000_8000, 32'hFFFF_FFFF);
        wr(8'h10, 32'h0000_8000);
        end_test("pin detach");
        wr(8'h18, 32'h0000_0000);
        cyc(2);
        rd(8'h14, 32'h0000_0005, 32'hFFFF_FFF5);
        frame_pend <= 1'b1;
        cyc(3);
        @(negedge core_clk);
        cmp_port({31'h0, irq}, 32'h0000_0000);
        wr(8'h18, 32'h0000_0008);
        cyc(1);
        @(negedge core_clk);
        cmp_port({31'h0, irq}, 32'h0000_0001);
        rd(8'h14, 32'h0000_0008, 32'h0000_000F);
        cyc(2);
        @(negedge core_clk);
        cmp_port({31'h0, irq}, 32'h0000_0000);
        rd(8'h0c, 32'h0000_1804, 32'hFFFF_FFFF);
        end_test("interrupt");
        conclude();
    end
endmodule : ihc_regs_tb_top
